// ### hsgf_pkg.sv
// package: register map, field layout, reset values and types of the supply guard block
package hsgf_pkg;
    // register offsets
    localparam logic [7:0] ADDR_GUARD_CFG = 8'h09;
    localparam logic [7:0] ADDR_THR_FIRST = 8'h0A;
    localparam logic [7:0] ADDR_THR_SECOND = 8'h0B;
    localparam logic [7:0] ADDR_FIRE_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h20;
    localparam logic [7:0] ADDR_INT_CLEAR = 8'h21;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h22;
    // reset values
    localparam logic [7:0] RST_GUARD_CFG = 8'h00;
    localparam logic [7:0] RST_THR_FIRST = 8'h92;
    localparam logic [7:0] RST_THR_SECOND = 8'h8D;
    localparam logic [3:0] RST_INT = 4'h0;
    // field positions
    localparam int LVL_SEL_LSB = 6;
    localparam int UV_SEL_LSB = 0;
    localparam int FIRE_BIT = 0;
    // level select encodings
    localparam logic [1:0] LVL_OFF = 2'h0;
    localparam logic [1:0] LVL_FIRST = 2'h1;
    localparam logic [1:0] LVL_BOTH = 2'h2;
    // cutoff ladder in millivolts
    localparam int UV_BASE_MV = 32'h0000_09C4;
    localparam int UV_STEP_MV = 32'h0000_0064;
    localparam int ADC_MAX_CODE = 32'h0000_00FF;
    // sequencer slot window
    localparam logic [7:0] SEQ_FIRST_SLOT = 8'h0F;
    localparam logic [7:0] SEQ_LAST_SLOT = 8'h16;
    // interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_UV = 2;
    localparam int IRQ_TRIG = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [1:0] {
        HSGF_MODE_RTP = 2'h0,
        HSGF_MODE_SEQ = 2'h1,
        HSGF_MODE_DIAG = 2'h2,
        HSGF_MODE_CAL = 2'h3
    } hsgf_mode_e;

    typedef enum logic [2:0] {
        HSGF_ST_IDLE = 3'h1,
        HSGF_ST_RUN = 3'h2,
        HSGF_ST_STBY = 3'h4
    } hsgf_state_e;

    // plain register-port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hsgf_req_s;

    // overdrive clamp candidates from the clamp registers
    typedef struct packed {
        logic [7:0] normal;
        logic [7:0] first;
        logic [7:0] second;
    } hsgf_clamp_s;
endpackage

// ### hsgf_sync.sv
// file: two-stage synchroniser for pin-domain inputs
`timescale 1ns/1ps
module hsgf_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ### hsgf_top.sv
// file: supply guard, battery-extension clamp choice and fire control
//
// Contract
// - level select 0 off, 1 first threshold only, 2 both thresholds.
// - supply under cutoff turns output stage off and enters standby at once.
// - cutoff code 0..7 maps 2.5 V to 3.2 V in 0.1 V steps.
// - first level enabled and supply below first threshold picks first clamp.
// - second level enabled and supply below second threshold picks second clamp.
// - supply sampled once at effect start; clamp held for whole effect.
// - writing one to fire bit starts process chosen by operating mode.
// - fire bit reads one while process runs; cleared by device on finish.
// - writing zero to fire bit while running aborts process immediately.
// - external trigger sets fire bit and starts process like a write.
// - sequencer mode plays slots from 0x0F through 0x16.
`timescale 1ns/1ps
module hsgf_top #(
    parameter int ADC_FULL_MV = 32'h0000_15E0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire hsgf_pkg::hsgf_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] supply_code,
    input wire logic ext_trig,
    input wire hsgf_pkg::hsgf_mode_e op_mode,
    input wire hsgf_pkg::hsgf_clamp_s clamp_in,
    input wire logic effect_start,
    input wire logic slot_done,
    input wire logic proc_done,
    output logic [7:0] od_limit,
    output logic [7:0] seq_slot,
    output logic proc_start,
    output logic proc_abort,
    output logic [1:0] proc_mode,
    output logic fire_busy,
    output logic stage_off,
    output logic standby,
    output logic irq
);
    logic [1:0] lvl_sel_r;
    logic [2:0] uv_sel_r;
    logic [7:0] thr_first_r;
    logic [7:0] thr_second_r;
    logic fire_r;
    logic [hsgf_pkg::IRQ_W-1:0] int_stat_r;
    logic [hsgf_pkg::IRQ_W-1:0] int_en_r;
    hsgf_pkg::hsgf_state_e state_r;
    hsgf_pkg::hsgf_state_e state_nxt;
    logic [7:0] sup_s;
    logic [7:0] sup_prev_r;
    logic [7:0] sup_r;
    logic trig_s;
    logic trig_d_r;
    logic trig_rise;
    logic [7:0] uv_code;
    logic uv_now;
    logic wr_fire;
    logic fire_one;
    logic fire_zero;
    logic go_req;
    logic start_ok;
    logic seq_end;
    logic finish;
    logic abort_ev;

    // pin-side supply code and trigger pass two flops before use
    hsgf_sync #(.W(9)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d({ext_trig, supply_code}),
        .q({trig_s, sup_s})
    );

    // multi-bit supply code: a value is taken only once two synced samples agree,
    // so a word caught mid-change never reaches the compares
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sup_prev_r <= '0;
            sup_r <= '0;
        end else begin
            sup_prev_r <= sup_s;
            if (sup_s == sup_prev_r) begin
                sup_r <= sup_s;
            end
        end
    end

    // cutoff in adc codes: (base + step*sel) * max / full scale
    function automatic logic [7:0] uv_to_code(input logic [2:0] sel);
        int mv;
        mv = hsgf_pkg::UV_BASE_MV + hsgf_pkg::UV_STEP_MV * int'(sel);
        return 8'((mv * hsgf_pkg::ADC_MAX_CODE) / ADC_FULL_MV);
    endfunction

    assign uv_code = uv_to_code(uv_sel_r);
    assign uv_now = sup_r < uv_code;

    // trigger edge: only the synchronised copy is looked at
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trig_s;
        end
    end
    assign trig_rise = trig_s & ~trig_d_r;

    // decode of the fire register write
    assign wr_fire = reg_req.wr && reg_req.addr == hsgf_pkg::ADDR_FIRE_CTRL;
    assign fire_one = wr_fire && reg_req.wdata[hsgf_pkg::FIRE_BIT];
    assign fire_zero = wr_fire && !reg_req.wdata[hsgf_pkg::FIRE_BIT];
    // trigger edge counts as a write of one
    assign go_req = fire_one || trig_rise;
    assign start_ok = state_r == hsgf_pkg::HSGF_ST_IDLE && go_req && !uv_now;
    // sequencer ends after the last slot
    assign seq_end = proc_mode == hsgf_pkg::HSGF_MODE_SEQ && slot_done
        && seq_slot == hsgf_pkg::SEQ_LAST_SLOT;
    assign finish = proc_mode == hsgf_pkg::HSGF_MODE_SEQ ? seq_end : proc_done;
    // clear write or undervoltage cancels a running process
    assign abort_ev = state_r == hsgf_pkg::HSGF_ST_RUN && (fire_zero || uv_now);

    // next state of the fire machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hsgf_pkg::HSGF_ST_IDLE: begin
                if (uv_now) begin
                    state_nxt = hsgf_pkg::HSGF_ST_STBY;
                end else if (start_ok) begin
                    state_nxt = hsgf_pkg::HSGF_ST_RUN;
                end
            end
            hsgf_pkg::HSGF_ST_RUN: begin
                if (uv_now) begin
                    state_nxt = hsgf_pkg::HSGF_ST_STBY;
                end else if (fire_zero || finish) begin
                    state_nxt = hsgf_pkg::HSGF_ST_IDLE;
                end
            end
            hsgf_pkg::HSGF_ST_STBY: begin
                if (!uv_now) begin
                    state_nxt = hsgf_pkg::HSGF_ST_IDLE;
                end
            end
            default: begin
                state_nxt = hsgf_pkg::HSGF_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= hsgf_pkg::HSGF_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // configuration registers; reserved bits are never stored
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lvl_sel_r <= hsgf_pkg::RST_GUARD_CFG[hsgf_pkg::LVL_SEL_LSB +: 2];
            uv_sel_r <= hsgf_pkg::RST_GUARD_CFG[hsgf_pkg::UV_SEL_LSB +: 3];
            thr_first_r <= hsgf_pkg::RST_THR_FIRST;
            thr_second_r <= hsgf_pkg::RST_THR_SECOND;
            int_en_r <= hsgf_pkg::RST_INT;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                hsgf_pkg::ADDR_GUARD_CFG: begin
                    lvl_sel_r <= reg_req.wdata[hsgf_pkg::LVL_SEL_LSB +: 2];
                    uv_sel_r <= reg_req.wdata[hsgf_pkg::UV_SEL_LSB +: 3];
                end
                hsgf_pkg::ADDR_THR_FIRST: thr_first_r <= reg_req.wdata;
                hsgf_pkg::ADDR_THR_SECOND: thr_second_r <= reg_req.wdata;
                hsgf_pkg::ADDR_INT_ENABLE: int_en_r <= reg_req.wdata[hsgf_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // fire bit set on start, cleared by the device on finish
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fire_r <= 1'b0;
        end else begin
            fire_r <= state_nxt == hsgf_pkg::HSGF_ST_RUN;
        end
    end

    // process control pulses; mode latched so a later mode change cannot
    // switch the running process
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            proc_start <= 1'b0;
            proc_abort <= 1'b0;
            proc_mode <= hsgf_pkg::HSGF_MODE_RTP;
        end else begin
            proc_start <= start_ok;
            proc_abort <= abort_ev;
            if (start_ok) begin
                proc_mode <= op_mode;
            end
        end
    end

    // walk the slot window in sequencer mode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_slot <= hsgf_pkg::SEQ_FIRST_SLOT;
        end else if (start_ok || state_r != hsgf_pkg::HSGF_ST_RUN) begin
            seq_slot <= hsgf_pkg::SEQ_FIRST_SLOT;
        end else if (slot_done && seq_slot != hsgf_pkg::SEQ_LAST_SLOT) begin
            seq_slot <= seq_slot + 8'h01;
        end
    end

    // output stage off and standby follow the compare with one flop
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage_off <= 1'b0;
            standby <= 1'b0;
            fire_busy <= 1'b0;
        end else begin
            stage_off <= uv_now;
            standby <= uv_now || state_nxt == hsgf_pkg::HSGF_ST_STBY;
            fire_busy <= state_nxt == hsgf_pkg::HSGF_ST_RUN;
        end
    end

    // clamp chosen once per effect from the sampled supply
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            od_limit <= '0;
        end else if (effect_start) begin
            // second threshold is the lower one, so it is checked first
            if (lvl_sel_r == hsgf_pkg::LVL_BOTH && sup_r < thr_second_r) begin
                od_limit <= clamp_in.second;
            // first threshold, enabled by level code 1 or 2
            end else if ((lvl_sel_r == hsgf_pkg::LVL_FIRST
                    || lvl_sel_r == hsgf_pkg::LVL_BOTH) && sup_r < thr_first_r) begin
                od_limit <= clamp_in.first;
            // feature off or supply high keeps the normal clamp
            end else begin
                od_limit <= clamp_in.normal;
            end
        end
    end

    // sticky event bits: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_stat_r <= hsgf_pkg::RST_INT;
        end else begin
            int_stat_r <= (int_stat_r & ~((reg_req.wr
                && reg_req.addr == hsgf_pkg::ADDR_INT_CLEAR)
                ? reg_req.wdata[hsgf_pkg::IRQ_W-1:0] : '0))
                | {trig_rise, uv_now && !stage_off, abort_ev,
                   state_r == hsgf_pkg::HSGF_ST_RUN && finish && !abort_ev};
        end
    end

    // level interrupt from enabled status
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_r & int_en_r);
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                hsgf_pkg::ADDR_GUARD_CFG: reg_rdata <= {lvl_sel_r, 3'h0, uv_sel_r};
                hsgf_pkg::ADDR_THR_FIRST: reg_rdata <= thr_first_r;
                hsgf_pkg::ADDR_THR_SECOND: reg_rdata <= thr_second_r;
                hsgf_pkg::ADDR_FIRE_CTRL: reg_rdata <= {7'h00, fire_r};
                hsgf_pkg::ADDR_INT_STATUS: reg_rdata <= {4'h0, int_stat_r};
                hsgf_pkg::ADDR_INT_ENABLE: reg_rdata <= {4'h0, int_en_r};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_uv_standby: assert property (uv_now |=> standby && stage_off)
        else $error("undervoltage did not force standby");
    a_uv_ladder: assert property (uv_sel_r != 3'h0
        |-> uv_code > uv_to_code(uv_sel_r - 3'h1))
        else $error("cutoff ladder not rising");
    a_clamp_second: assert property (effect_start && lvl_sel_r == hsgf_pkg::LVL_BOTH
        && sup_r < thr_second_r |=> od_limit == $past(clamp_in.second))
        else $error("second clamp not applied");
    a_clamp_first: assert property (effect_start && lvl_sel_r == hsgf_pkg::LVL_FIRST
        && sup_r < thr_first_r |=> od_limit == $past(clamp_in.first))
        else $error("first clamp not applied");
    a_clamp_normal: assert property (effect_start && lvl_sel_r == hsgf_pkg::LVL_OFF
        |=> od_limit == $past(clamp_in.normal))
        else $error("normal clamp not applied when feature off");
    a_clamp_high: assert property (effect_start && lvl_sel_r != hsgf_pkg::LVL_OFF
        && sup_r >= thr_first_r && (lvl_sel_r != hsgf_pkg::LVL_BOTH || sup_r >= thr_second_r)
        |=> od_limit == $past(clamp_in.normal))
        else $error("normal clamp not applied above thresholds");
    a_clamp_hold: assert property (!effect_start |=> $stable(od_limit))
        else $error("clamp changed inside an effect");
    a_fire_start: assert property (start_ok |=> fire_r && proc_start
        && proc_mode == $past(op_mode))
        else $error("fire did not start selected process");
    a_fire_finish: assert property (state_r == hsgf_pkg::HSGF_ST_RUN && finish
        && !uv_now && !fire_zero |=> !fire_r ##1 !fire_r)
        else $error("fire bit not cleared on completion");
    a_fire_abort: assert property (state_r == hsgf_pkg::HSGF_ST_RUN && fire_zero
        |=> proc_abort && !fire_r)
        else $error("clear write did not abort");
    a_trig_fire: assert property (trig_rise && state_r == hsgf_pkg::HSGF_ST_IDLE
        && !uv_now |=> fire_r && proc_start)
        else $error("trigger did not fire");
    a_slot_window: assert property (seq_slot >= hsgf_pkg::SEQ_FIRST_SLOT
        && seq_slot <= hsgf_pkg::SEQ_LAST_SLOT)
        else $error("slot pointer left the window");
    a_rsvd_zero: assert property (reg_req.rd && reg_req.addr == hsgf_pkg::ADDR_FIRE_CTRL
        |=> reg_rdata[7:1] == 7'h00)
        else $error("reserved bits read nonzero");
    a_lvl_three: assert property (effect_start && lvl_sel_r == 2'h3
        |=> od_limit == $past(clamp_in.normal))
        else $error("undefined level code enabled a threshold");

    c_seq_run: cover property (start_ok && op_mode == hsgf_pkg::HSGF_MODE_SEQ
        ##[1:200] seq_end);
    c_abort: cover property (fire_r ##1 fire_zero);
    c_uv_trip: cover property (fire_r ##1 uv_now);
    c_clamp_second: cover property (effect_start && lvl_sel_r == hsgf_pkg::LVL_BOTH
        && sup_r < thr_second_r);
    c_trig_start: cover property (trig_rise && state_r == hsgf_pkg::HSGF_ST_IDLE ##1 fire_r);
endmodule

// ### hsgf_engine_model.sv
// playback engine stand-in that paces slot and process completion pulses
`timescale 1ns/1ps
module hsgf_engine_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic proc_start,
    input wire logic fire_busy,
    input wire logic [1:0] proc_mode,
    input wire logic stall,
    output logic slot_done,
    output logic proc_done
);
    logic [3:0] cnt_r;

    // stops on abort
    // pacing runs only while the block reports a live process, so an abort silences it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h3;
            slot_done <= 1'b0;
            proc_done <= 1'b0;
        end else begin
            slot_done <= 1'b0;
            proc_done <= 1'b0;
            if (proc_start) begin
                cnt_r <= 4'h3;
            end else if (fire_busy && !stall) begin
                cnt_r <= (cnt_r == 4'h0) ? 4'h3 : cnt_r - 4'h1;
                // sequencer mode reports per slot, other modes report one finish
                if (cnt_r == 4'h0) begin
                    slot_done <= (proc_mode == hsgf_pkg::HSGF_MODE_SEQ);
                    proc_done <= (proc_mode != hsgf_pkg::HSGF_MODE_SEQ);
                end
            end
        end
    end
endmodule

// ### hsgf_top_tb.sv
// testbench: register port, clamp choice, fire control and supply guard
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module hsgf_top_tb;
    localparam int FULL = 5600;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    hsgf_pkg::hsgf_req_s req = '0;
    logic [7:0] rdata, od_limit, seq_slot;
    logic [7:0] supply = 8'hC0;
    logic ext_trig = 1'b0;
    logic eff = 1'b0;
    logic stall = 1'b0;
    hsgf_pkg::hsgf_mode_e mode = hsgf_pkg::HSGF_MODE_SEQ;
    // first clamp kept at or above second
    hsgf_pkg::hsgf_clamp_s clamp = '{normal: 8'h40, first: 8'h60, second: 8'h50};
    logic slot_done, proc_done, proc_start, proc_abort, fire_busy, stage_off, standby, irq;
    logic [1:0] proc_mode;
    int checked = 0, miscompares = 0, starts = 0, slots = 0, cyc = 0, s, cut;
    logic [1:0] lv[6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1};
    logic [7:0] sp[6] = '{8'h8C, 8'h8C, 8'h8C, 8'h8F, 8'h8C, 8'h96};
    logic [7:0] ex[6] = '{8'h40, 8'h60, 8'h50, 8'h60, 8'h40, 8'h40};
    hsgf_pkg::hsgf_mode_e ml[4] = '{hsgf_pkg::HSGF_MODE_SEQ, hsgf_pkg::HSGF_MODE_DIAG,
        hsgf_pkg::HSGF_MODE_CAL, hsgf_pkg::HSGF_MODE_RTP};

    hsgf_top #(.ADC_FULL_MV(FULL)) dut (.core_clk(core_clk), .rst(rst), .reg_req(req),
        .reg_rdata(rdata), .supply_code(supply), .ext_trig(ext_trig), .op_mode(mode),
        .clamp_in(clamp), .effect_start(eff), .slot_done(slot_done), .proc_done(proc_done),
        .od_limit(od_limit), .seq_slot(seq_slot), .proc_start(proc_start),
        .proc_abort(proc_abort), .proc_mode(proc_mode), .fire_busy(fire_busy),
        .stage_off(stage_off), .standby(standby), .irq(irq));
    hsgf_engine_model eng (.core_clk(core_clk), .rst(rst), .proc_start(proc_start),
        .fire_busy(fire_busy), .proc_mode(proc_mode), .stall(stall),
        .slot_done(slot_done), .proc_done(proc_done));

    // clock: 50 ns period
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // event counters and hang guard; the ceiling is far above the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (proc_start === 1'b1) starts++;
        if (slot_done === 1'b1) slots++;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end

    // one-cycle strobe, returns just after the edge that took it
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
        req <= '0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1'b1);
    endtask
    task automatic chkreg(input logic [7:0] a, input logic [7:0] e);
        acc(a, 8'h00, 1'b0);
        `CHK(rdata, e)
    endtask
    task automatic cw(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 200 && fire_busy !== 1'b0; k++) cw(1);
        `CHK(fire_busy, 1'b0)
    endtask
    task automatic effect(input logic [1:0] l, input logic [7:0] sv);
        wr(hsgf_pkg::ADDR_GUARD_CFG, {l, 6'h00});
        supply <= sv;
        cw(5);
        eff <= 1'b1;
        @(posedge core_clk);
        eff <= 1'b0;
        #1;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        cw(6);
        chkreg(hsgf_pkg::ADDR_GUARD_CFG, 8'h00);
        chkreg(hsgf_pkg::ADDR_THR_FIRST, 8'h92);
        chkreg(hsgf_pkg::ADDR_THR_SECOND, 8'h8D);
        chkreg(hsgf_pkg::ADDR_FIRE_CTRL, 8'h00);
        chkreg(8'h30, 8'h00);
        wr(hsgf_pkg::ADDR_GUARD_CFG, 8'hFF);
        chkreg(hsgf_pkg::ADDR_GUARD_CFG, 8'hC7);
        wr(hsgf_pkg::ADDR_FIRE_CTRL, 8'hFE);
        chkreg(hsgf_pkg::ADDR_FIRE_CTRL, 8'h00);
        chkreg(hsgf_pkg::ADDR_INT_CLEAR, 8'h00);
        $display("test registers done");
        // defaults keep first threshold above second
        for (int i = 0; i < 6; i++) begin
            effect(lv[i], sp[i]);
            `CHK(od_limit, ex[i])
        end
        effect(2'h2, 8'h8C);
        supply <= 8'hC0;
        cw(6);
        `CHK(od_limit, 8'h50)
        $display("test clamp done");
        wr(hsgf_pkg::ADDR_INT_CLEAR, 8'h0F);
        wr(hsgf_pkg::ADDR_INT_ENABLE, 8'hF1);
        chkreg(hsgf_pkg::ADDR_INT_ENABLE, 8'h01);
        foreach (ml[i]) begin
            mode <= ml[i];
            s = slots;
            wr(hsgf_pkg::ADDR_FIRE_CTRL, 8'h01);
            `CHK(proc_start, 1'b1)
            `CHK(proc_mode, ml[i])
            if (i == 0) `CHK(seq_slot, 8'h0F)
            chkreg(hsgf_pkg::ADDR_FIRE_CTRL, 8'h01);
            wait_idle();
            chkreg(hsgf_pkg::ADDR_FIRE_CTRL, 8'h00);
            if (i == 0) `CHK(slots - s, 8)
            `CHK(irq, 1'b1)
            chkreg(hsgf_pkg::ADDR_INT_STATUS, 8'h01);
            wr(hsgf_pkg::ADDR_INT_CLEAR, 8'h01);
            cw(2);
            `CHK(irq, 1'b0)
        end
        $display("test fire modes done");
        stall <= 1'b1;
        mode <= hsgf_pkg::HSGF_MODE_SEQ;
        wr(hsgf_pkg::ADDR_FIRE_CTRL, 8'h01);
        cw(1);
        s = starts;
        wr(hsgf_pkg::ADDR_FIRE_CTRL, 8'h01);
        cw(1);
        `CHK(starts, s)
        wr(hsgf_pkg::ADDR_FIRE_CTRL, 8'h00);
        `CHK(proc_abort, 1'b1)
        `CHK(fire_busy, 1'b0)
        chkreg(hsgf_pkg::ADDR_INT_STATUS, 8'h02);
        `CHK(irq, 1'b0)
        $display("test abort done");
        wr(hsgf_pkg::ADDR_INT_CLEAR, 8'h0F);
        wr(hsgf_pkg::ADDR_INT_ENABLE, 8'h08);
        mode <= hsgf_pkg::HSGF_MODE_DIAG;
        ext_trig <= 1'b1;
        for (int k = 0; k < 10 && fire_busy !== 1'b1; k++) cw(1);
        chkreg(hsgf_pkg::ADDR_FIRE_CTRL, 8'h01);
        `CHK(irq, 1'b1)
        stall <= 1'b0;
        wait_idle();
        ext_trig <= 1'b0;
        wr(hsgf_pkg::ADDR_INT_CLEAR, 8'h0F);
        cw(2);
        `CHK(irq, 1'b0)
        $display("test trigger done");
        for (int sel = 0; sel < 8; sel++) begin
            wr(hsgf_pkg::ADDR_GUARD_CFG, 8'(sel));
            cut = (hsgf_pkg::UV_BASE_MV + hsgf_pkg::UV_STEP_MV * sel) * 255 / FULL;
            for (int d = 0; d < 2; d++) begin
                supply <= 8'(cut - d);
                cw(5);
                `CHK(stage_off, 1'(d))
                if (d == 1) `CHK(standby, 1'b1)
            end
            supply <= 8'hC0;
            cw(5);
        end
        stall <= 1'b1;
        wr(hsgf_pkg::ADDR_FIRE_CTRL, 8'h01);
        supply <= 8'h10;
        cw(5);
        `CHK(fire_busy, 1'b0)
        wr(hsgf_pkg::ADDR_FIRE_CTRL, 8'h01);
        `CHK(proc_start, 1'b0)
        $display("test undervoltage done");
        results();
    end
endmodule
